// [verilog/berc_pkg.sv]
// Constants for the bit error rate checker.
// Assumes a 250 MHz system clock and a word-wide register port.
`default_nettype none
package berc_pkg;
  // ****************
  // Timing
  // ****************
  localparam int CLK_MHZ  = 250;
  localparam int T1_NS    = 40;
  localparam int T2_NS    = 40;
  localparam int PULSE_NS = 100;
  localparam int T1_CYC    = (T1_NS * CLK_MHZ + 999) / 1000;
  localparam int T2_CYC    = (T2_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  // ****************
  // Sequence and counts
  // ****************
  localparam int PRBS_LEN = 9;
  localparam int PRBS_TAP = 5;
  localparam int SYNC_RUN = 18;
  localparam int IGN_RUN  = 160;
  localparam logic [31:0] DEF_TOTAL  = 32'd10000;
  localparam logic [15:0] DEF_CYCLES = 16'h0001;
  // ****************
  // Register offsets
  // ****************
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_CLK_DLY  = 8'h04;
  localparam logic [7:0] OFF_GATE_DLY = 8'h08;
  localparam logic [7:0] OFF_BIT_DLY  = 8'h0c;
  localparam logic [7:0] OFF_TOTAL    = 8'h10;
  localparam logic [7:0] OFF_RESYNC   = 8'h14;
  localparam logic [7:0] OFF_FAIL_LIM = 8'h18;
  localparam logic [7:0] OFF_CYCLES   = 8'h1c;
  localparam logic [7:0] OFF_STATUS   = 8'h20;
  localparam logic [7:0] OFF_RES_TOT  = 8'h24;
  localparam logic [7:0] OFF_RES_ERR  = 8'h28;
  localparam logic [7:0] OFF_CYC_DONE = 8'h2c;
  // ****************
  // Control bit positions
  // ****************
  localparam int C_GATE_EN  = 0;
  localparam int C_GATE_POL = 1;
  localparam int C_CLK_DLY  = 2;
  localparam int C_GATE_DLY = 3;
  localparam int C_BIT_DLY  = 4;
  localparam int C_RESYNC   = 5;
  localparam int C_IGN_EN   = 6;
  localparam int C_IGN_VAL  = 7;
  localparam int C_FAILHOLD = 8;
  localparam int C_TRIG     = 9;
  // ****************
  // Sequencer states
  // ****************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ARM   = 3'b001,
    ST_SKIP  = 3'b010,
    ST_FILL  = 3'b011,
    ST_CHECK = 3'b100,
    ST_RUN   = 3'b101,
    ST_PULSE = 3'b110,
    ST_TAIL  = 3'b111
  } berc_st_t;
endpackage
`default_nettype wire

// [verilog/berc_top.sv]
// Bit error rate checker: nine-stage PRBS receiver with gating and delays.
// Assumes measured pins are asynchronous and run well below clk_i / 2.
// What this block does
// - Gating on: clock edges count only while qualifier matches polarity.
// - Clock delay on: incoming clock is delayed by a programmed amount.
// - Gate delay: qualifier delayed by programmed measured-clock periods.
// - Clock actually used appears on the result pulse output.
// - After trigger the reference syncs from the first arriving bits.
// - Bit delay skips bits, then lengthens the error-free sync run.
// - Auto resync restarts a single-cycle measurement when errors exceed the limit.
// - Continuous sequences checked at bit rates up to 90 MHz.
// - Ignore enabled: runs of 160+ selected-value bits are not errors.
// - Ignored bits still add to the total bit count.
// - Cycle-end mode gives a fresh verdict for each cycle.
// - Fail-hold mode keeps a fail until the repeat loop ends.
// - Repeat loops sync only before the first cycle, then keep tracking.
// - Established sync is held during repeats even as errors grow.
// - Sync lost during repeats is not regained until a new start.
// - Active output rises after trigger; triggers ignored while high.
// - Measurement-in-progress is readable in a status register.
// - Result pulse ends before the active output falls.
// - Active rises an interval after trigger, falls after pulse ends.
// - Bits per cycle default to 10000.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module berc_top #(
  parameter int DLY_DEPTH  = 64,
  parameter int GDLY_DEPTH = 16
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        measured_clock_input_i,
  input  wire logic        measured_data_input_i,
  input  wire logic        clock_qualifier_input_i,
  input  wire logic        trigger_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             measurement_active_output_o,
  output logic             result_pulse_output_o
);
  localparam int DW = $clog2(DLY_DEPTH);
  localparam int GW = $clog2(GDLY_DEPTH);

  typedef struct packed {
    logic                  mclk_s1;
    logic                  mclk_s2;
    logic                  data_s1;
    logic                  data_s2;
    logic                  qual_s1;
    logic                  qual_s2;
    logic                  trig_s1;
    logic                  trig_s2;
    logic                  trig_p;
    logic [DLY_DEPTH-1:0]  dly;
    logic [GDLY_DEPTH-1:0] gline;
    logic                  eff_p;
    logic [9:0]            ctl;
    logic [DW-1:0]         clk_dly;
    logic [GW-1:0]         gate_dly;
    logic [15:0]           bit_dly;
    logic [31:0]           tgt;
    logic [31:0]           rs_lim;
    logic [31:0]           f_lim;
    logic [15:0]           cycles;
    berc_pkg::berc_st_t    st;
    logic [15:0]           tmr;
    logic [15:0]           fill;
    logic [8:0]            lfsr;
    logic [31:0]           tot;
    logic [31:0]           err;
    logic [7:0]            pend;
    logic [7:0]            run;
    logic [15:0]           cyc;
    logic                  locked;
    logic                  lost;
    logic                  fail;
    logic                  valid;
    logic [31:0]           res_tot;
    logic [31:0]           res_err;
    logic                  active;
    logic                  pulse;
    logic [31:0]           rdata;
  } berc_reg_t;

  berc_reg_t q;
  berc_reg_t n;
  logic [1:0] rst_s;
  logic       rst_n;

  // ****************
  // Reset release
  // ****************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s <= 2'h0;
    end else begin
      rst_s <= {rst_s[0], 1'b1};
    end
  end
  assign rst_n = rst_s[1];

  // ****************
  // Next state
  // ****************
  logic        eff;
  logic        rise;
  logic        gate;
  logic        ok;
  logic        bit_v;
  logic        rx;
  logic        refb;
  logic        e;
  logic        same;
  logic        trig;
  logic        single;
  logic [31:0] nerr;
  logic [15:0] need;
  logic [15:0] ncyc;

  always_comb begin
    n = q;
    nerr = 32'h0;
    ncyc = 16'h0;
    n.mclk_s1 = measured_clock_input_i;
    n.mclk_s2 = q.mclk_s1;
    n.data_s1 = measured_data_input_i;
    n.data_s2 = q.data_s1;
    n.qual_s1 = clock_qualifier_input_i;
    n.qual_s2 = q.qual_s1;
    n.trig_s1 = trigger_i;
    n.trig_s2 = q.trig_s1;
    n.trig_p  = q.trig_s2;
    n.dly = {q.dly[DLY_DEPTH-2:0], q.mclk_s2};
    eff = q.ctl[berc_pkg::C_CLK_DLY] ? q.dly[q.clk_dly] : q.mclk_s2;
    n.eff_p = eff;
    // sampled edge detect, rate bound by clk_i
    rise = eff & ~q.eff_p;
    if (rise) begin
      n.gline = {q.gline[GDLY_DEPTH-2:0], q.qual_s2};
    end
    gate = q.ctl[berc_pkg::C_GATE_DLY] ? q.gline[q.gate_dly] : q.qual_s2;
    ok = !q.ctl[berc_pkg::C_GATE_EN] || (gate == q.ctl[berc_pkg::C_GATE_POL]);
    bit_v = rise & ok;
    rx = q.data_s2;
    refb = q.lfsr[berc_pkg::PRBS_LEN-1] ^ q.lfsr[berc_pkg::PRBS_TAP-1];
    e = rx ^ refb;
    same = q.ctl[berc_pkg::C_IGN_EN] && (rx == q.ctl[berc_pkg::C_IGN_VAL]);
    single = (q.cycles <= 16'h0001);
    need = 16'(berc_pkg::SYNC_RUN) + (q.ctl[berc_pkg::C_BIT_DLY] ? q.bit_dly : 16'h0);
    trig = (q.trig_s2 & ~q.trig_p)
         | (wr_i && addr_i == berc_pkg::OFF_CTRL && wdata_i[berc_pkg::C_TRIG]);

    // ****************
    // Register port
    // ****************
    if (wr_i) begin
      if (addr_i == berc_pkg::OFF_CTRL) begin
        n.ctl = {1'b0, wdata_i[8:0]};
      end else if (addr_i == berc_pkg::OFF_CLK_DLY) begin
        n.clk_dly = wdata_i[DW-1:0];
      end else if (addr_i == berc_pkg::OFF_GATE_DLY) begin
        n.gate_dly = wdata_i[GW-1:0];
      end else if (addr_i == berc_pkg::OFF_BIT_DLY) begin
        n.bit_dly = wdata_i[15:0];
      end else if (addr_i == berc_pkg::OFF_TOTAL) begin
        n.tgt = wdata_i;
      end else if (addr_i == berc_pkg::OFF_RESYNC) begin
        n.rs_lim = wdata_i;
      end else if (addr_i == berc_pkg::OFF_FAIL_LIM) begin
        n.f_lim = wdata_i;
      end else if (addr_i == berc_pkg::OFF_CYCLES) begin
        n.cycles = wdata_i[15:0];
      end
    end
    n.rdata = 32'h0;
    if (rd_i) begin
      if (addr_i == berc_pkg::OFF_CTRL) begin
        n.rdata = {22'h0, q.ctl};
      end else if (addr_i == berc_pkg::OFF_CLK_DLY) begin
        n.rdata = 32'(q.clk_dly);
      end else if (addr_i == berc_pkg::OFF_GATE_DLY) begin
        n.rdata = 32'(q.gate_dly);
      end else if (addr_i == berc_pkg::OFF_BIT_DLY) begin
        n.rdata = {16'h0, q.bit_dly};
      end else if (addr_i == berc_pkg::OFF_TOTAL) begin
        n.rdata = q.tgt;
      end else if (addr_i == berc_pkg::OFF_RESYNC) begin
        n.rdata = q.rs_lim;
      end else if (addr_i == berc_pkg::OFF_FAIL_LIM) begin
        n.rdata = q.f_lim;
      end else if (addr_i == berc_pkg::OFF_CYCLES) begin
        n.rdata = {16'h0, q.cycles};
      end else if (addr_i == berc_pkg::OFF_STATUS) begin
        n.rdata = {24'h0, q.st, q.valid, q.fail, q.lost, q.locked, q.active};
      end else if (addr_i == berc_pkg::OFF_RES_TOT) begin
        n.rdata = q.res_tot;
      end else if (addr_i == berc_pkg::OFF_RES_ERR) begin
        n.rdata = q.res_err;
      end else if (addr_i == berc_pkg::OFF_CYC_DONE) begin
        n.rdata = {16'h0, q.cyc};
      end
    end

    // ****************
    // Sequencer
    // ****************
    // used clock mirrored while measuring
    n.pulse = eff & ok & q.active;
    case (q.st)
      berc_pkg::ST_IDLE: begin
        n.pulse = 1'b0;
        if (trig) begin
          n.st = berc_pkg::ST_ARM;
          n.tmr = 16'h0;
          n.fail = 1'b0;
          n.cyc = 16'h0;
          n.lost = 1'b0;
          n.locked = 1'b0;
        end
      end
      berc_pkg::ST_ARM: begin
        n.tmr = q.tmr + 16'h1;
        if (q.tmr == 16'(berc_pkg::T1_CYC - 1)) begin
          n.active = 1'b1;
          n.fill = 16'h0;
          n.tot = 32'h0;
          n.err = 32'h0;
          n.pend = 8'h0;
          n.run = 8'h0;
          if (q.ctl[berc_pkg::C_BIT_DLY] && q.bit_dly != 16'h0) begin
            n.st = berc_pkg::ST_SKIP;
          end else begin
            n.st = berc_pkg::ST_FILL;
          end
        end
      end
      berc_pkg::ST_SKIP: begin
        if (bit_v) begin
          n.fill = q.fill + 16'h1;
          if (q.fill == q.bit_dly - 16'h1) begin
            n.st = berc_pkg::ST_FILL;
            n.fill = 16'h0;
          end
        end
      end
      berc_pkg::ST_FILL: begin
        if (bit_v) begin
          n.lfsr = {q.lfsr[7:0], rx};
          n.fill = q.fill + 16'h1;
          if (q.fill == 16'(berc_pkg::PRBS_LEN - 1)) begin
            n.st = berc_pkg::ST_CHECK;
            n.fill = 16'h0;
          end
        end
      end
      berc_pkg::ST_CHECK: begin
        if (bit_v) begin
          if (e) begin
            n.lfsr = {q.lfsr[7:0], rx};
            n.st = berc_pkg::ST_FILL;
            n.fill = 16'h1;
          end else begin
            n.lfsr = {q.lfsr[7:0], refb};
            n.fill = q.fill + 16'h1;
            if (q.fill == need - 16'h1) begin
              n.st = berc_pkg::ST_RUN;
              n.locked = 1'b1;
            end
          end
        end
      end
      berc_pkg::ST_RUN: begin
        if (bit_v) begin
          n.lfsr = {q.lfsr[7:0], refb};
          n.tot = q.tot + 32'h1;
          nerr = q.err;
          if (same) begin
            if (q.run >= 8'(berc_pkg::IGN_RUN - 1)) begin
              n.run = 8'(berc_pkg::IGN_RUN);
              n.pend = 8'h0;
            end else begin
              n.run = q.run + 8'h1;
              n.pend = q.pend + 8'(e);
            end
          end else begin
            nerr = q.err + 32'(q.pend) + 32'(e);
            n.pend = 8'h0;
            n.run = 8'h0;
          end
          n.err = nerr;
          if (q.ctl[berc_pkg::C_RESYNC] && nerr > q.rs_lim) begin
            if (single) begin
              n.st = berc_pkg::ST_FILL;
              n.fill = 16'h0;
              n.tot = 32'h0;
              n.err = 32'h0;
              n.pend = 8'h0;
              n.run = 8'h0;
              n.locked = 1'b0;
            end else begin
              // lost stays lost in a loop
              n.lost = 1'b1;
            end
          end
          if (n.tot == q.tgt) begin
            nerr = nerr + 32'(n.pend);
            n.res_tot = n.tot;
            n.res_err = nerr;
            if (q.ctl[berc_pkg::C_FAILHOLD]) begin
              n.fail = q.fail | (nerr > q.f_lim);
            end else begin
              n.fail = (nerr > q.f_lim);
            end
            ncyc = q.cyc + 16'h1;
            n.cyc = ncyc;
            n.tot = 32'h0;
            n.err = 32'h0;
            n.pend = 8'h0;
            n.run = 8'h0;
            if (single || ncyc >= q.cycles) begin
              n.st = berc_pkg::ST_PULSE;
              n.tmr = 16'h0;
            end else begin
              n.st = berc_pkg::ST_RUN;
            end
          end
        end
      end
      berc_pkg::ST_PULSE: begin
        n.pulse = 1'b1;
        n.tmr = q.tmr + 16'h1;
        if (q.tmr == 16'(berc_pkg::PULSE_CYC - 1)) begin
          n.st = berc_pkg::ST_TAIL;
          n.tmr = 16'h0;
          n.pulse = 1'b0;
        end
      end
      berc_pkg::ST_TAIL: begin
        n.pulse = 1'b0;
        n.tmr = q.tmr + 16'h1;
        if (q.tmr == 16'(berc_pkg::T2_CYC - 1)) begin
          n.st = berc_pkg::ST_IDLE;
          n.active = 1'b0;
          n.valid = 1'b1;
        end
      end
      default: begin
        n.st = berc_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************
  // State register
  // ****************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.tgt <= berc_pkg::DEF_TOTAL;
      q.cycles <= berc_pkg::DEF_CYCLES;
      q.rs_lim <= 32'hffffffff;
    end else begin
      q <= n;
    end
  end

  assign rdata_o = q.rdata;
  assign measurement_active_output_o = q.active;
  assign result_pulse_output_o = q.pulse;
endmodule // berc_top
`default_nettype wire

// [verification/berc_assertions.sv]
// Port checker for the bit error rate block.
// Bound to berc_top from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module berc_assertions (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        trigger_i,
  input wire logic [7:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        measurement_active_output_o,
  input wire logic        result_pulse_output_o
);
  // ****************
  // Pulse run lengths
  // ****************
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [7:0] last_hi_q;
  wire  logic act = measurement_active_output_o;
  wire  logic pls = result_pulse_output_o;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hi_q      <= 8'h00;
      lo_q      <= 8'h00;
      last_hi_q <= 8'h00;
    end else begin
      if (pls && hi_q != 8'hff) hi_q <= hi_q + 8'h01;
      else if (!pls) hi_q <= 8'h00;
      if (!pls && lo_q != 8'hff) lo_q <= lo_q + 8'h01;
      else if (pls) lo_q <= 8'h00;
      if (!pls && hi_q != 8'h00) last_hi_q <= hi_q;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ****************
  // Properties
  // ****************
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero without a read");
  a_unmapped_zero: assert property (rd_i && addr_i == 8'hfc |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_status_active: assert property (rd_i && addr_i == berc_pkg::OFF_STATUS && act
    && $past(act) |=> rdata_o[0])
    else $error("status does not show measurement");
  a_trig_to_active: assert property ($rose(trigger_i) && !act |-> ##[11:15] act)
    else $error("active late after trigger");
  a_active_hold: assert property ($rose(act) |-> act [*8])
    else $error("active dropped early");
  a_idle_quiet: assert property (!act |-> !pls)
    else $error("result pulse outside measurement");
  a_end_pulse: assert property ($fell(act) |-> last_hi_q == berc_pkg::PULSE_CYC)
    else $error("result pulse length wrong");
  a_end_gap: assert property ($fell(act) |-> lo_q >= 8'd8 && lo_q <= 8'd12)
    else $error("active fell at wrong time after pulse");
endmodule // berc_assertions
`default_nettype wire

// [verification/berc_uut_model.sv]
// Unit under test model: nine-stage sequence with its own bit clock.
// Clock stands low while not running; data then toggles.
`timescale 1ns/1ps
`default_nettype none
module berc_uut_model (
  input  wire logic run_i,
  input  wire logic err_i,
  input  wire logic hold_i,
  output logic      mclk_o,
  output logic      mdata_o
);
  logic [8:0] lfsr;
  logic       nb;
  initial begin
    lfsr    = 9'h1ff;
    mclk_o  = 1'b0;
    mdata_o = 1'b0;
    forever begin
      #62.5;
      if (run_i) begin
        mclk_o = ~mclk_o;
        if (!mclk_o) begin
          nb      = lfsr[8] ^ lfsr[4];
          lfsr    = {lfsr[7:0], nb};
          mdata_o = hold_i ? 1'b0 : nb ^ err_i;
        end
      end else begin
        mclk_o  = 1'b0;
        mdata_o = ~mdata_o;
      end
    end
  end
endmodule // berc_uut_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for berc_top with a unit under test model.
// Registers reached over the plain strobe port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i, reset_n_i, trig, qual, wr, rd, run, err, hold;
  logic        act, pls, mclk, mdata;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  int          n_fail, comparisons, hi;
  logic [31:0] ectl [4];
  logic [31:0] ecy  [4] = '{32'h1, 32'h1, 32'h2, 32'h2};
  logic [31:0] eer  [4] = '{32'h3, 32'h0, 32'h0, 32'h0};
  logic [31:0] efl  [4] = '{32'h8, 32'h0, 32'h8, 32'h0};
  logic [31:0] elo  [4] = '{32'h0, 32'h0, 32'h0, 32'h4};
  logic [31:0] cctl [4];
  berc_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .measured_clock_input_i(mclk), .measured_data_input_i(mdata),
    .clock_qualifier_input_i(qual), .trigger_i(trig), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .measurement_active_output_o(act), .result_pulse_output_o(pls));
  berc_uut_model u_uut (.run_i(run), .err_i(err), .hold_i(hold),
    .mclk_o(mclk), .mdata_o(mdata));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ****************
  // Tasks
  // ****************
  task automatic wrap_up();
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd32(a, v);
    chk(v, e);
  endtask
  task automatic wait_act(input logic l, input int n);
    for (int i = 0; i < n && act !== l; i++) @(negedge clk_i);
    if (act !== l) begin
      chk({31'h0, act}, {31'h0, l});
      wrap_up();
    end
  endtask
  task automatic pulse();
    repeat (4) @(posedge clk_i);
    trig <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig <= 1'b0;
  endtask
  task automatic go(input logic [31:0] c);
    wr32(berc_pkg::OFF_CTRL, c);
    // Software trigger bit starts the run without the pin
    if (c[berc_pkg::C_TRIG] == 1'b0) begin
      pulse();
    end
    wait_act(1'b1, 40);
    rd32(berc_pkg::OFF_STATUS, v);
    chk(v & 32'h1, 32'h1);
    pulse();
  endtask
  task automatic fin();
    wait_act(1'b0, 40000);
    rd32(berc_pkg::OFF_STATUS, v);
    chk(v & 32'h11, 32'h10);
  endtask
  task automatic wait_lock();
    v = 32'h0;
    for (int i = 0; i < 2000 && v[1] !== 1'b1; i++) rd32(berc_pkg::OFF_STATUS, v);
    if (v[1] !== 1'b1) begin
      chk(v & 32'h2, 32'h2);
      wrap_up();
    end
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    reset_n_i = 1'b0;
    {trig, qual, wr, rd, run, err, hold} = 7'h00;
    addr = 8'h00;
    wdata = 32'h0;
    n_fail = 0;
    comparisons = 0;
    ectl = '{32'h0, 32'h1 << berc_pkg::C_RESYNC, 32'h1 << berc_pkg::C_FAILHOLD,
             32'h1 << berc_pkg::C_RESYNC};
    cctl = '{32'h0, 32'h1 << berc_pkg::C_BIT_DLY, 32'h1 << berc_pkg::C_CLK_DLY,
             32'h1 << berc_pkg::C_RESYNC};
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rc(berc_pkg::OFF_TOTAL, 32'd10000);
    rc(berc_pkg::OFF_CYCLES, 32'h1);
    rc(berc_pkg::OFF_RESYNC, 32'hffffffff);
    rc(berc_pkg::OFF_CTRL, 32'h0);
    rc(8'hfc, 32'h0);
    wr32(berc_pkg::OFF_STATUS, 32'hffffffff);
    rc(berc_pkg::OFF_STATUS, 32'h0);
    wr32(berc_pkg::OFF_TOTAL, 32'd128);
    wr32(berc_pkg::OFF_BIT_DLY, 32'd9);
    wr32(berc_pkg::OFF_CLK_DLY, 32'd8);
    run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      go(cctl[i]);
      fin();
      rc(berc_pkg::OFF_RES_TOT, 32'd128);
      rc(berc_pkg::OFF_RES_ERR, 32'h0);
      rc(berc_pkg::OFF_CYC_DONE, 32'h1);
    end
    wr32(berc_pkg::OFF_GATE_DLY, 32'h2);
    rc(berc_pkg::OFF_GATE_DLY, 32'h2);
    for (int p = 0; p < 2; p++) begin
      qual <= (p == 0);
      go((32'h1 << berc_pkg::C_GATE_EN) | (p << berc_pkg::C_GATE_POL)
         | (p << berc_pkg::C_GATE_DLY));
      repeat (1500) @(posedge clk_i);
      // Blocked clock leaves the sequencer in fill; valid kept from the last run
      rc(berc_pkg::OFF_STATUS, 32'h11 | (32'h3 << 5));
      qual <= (p == 1);
      fin();
      rc(berc_pkg::OFF_RES_TOT, 32'd128);
    end
    wr32(berc_pkg::OFF_TOTAL, 32'd320);
    go((32'h1 << berc_pkg::C_IGN_EN) | (32'h1 << berc_pkg::C_TRIG));
    wait_lock();
    rc(berc_pkg::OFF_CTRL, 32'h1 << berc_pkg::C_IGN_EN);
    hi = 0;
    repeat (64) begin
      @(posedge clk_i);
      hi += pls;
    end
    chk({31'h0, hi >= 28 && hi <= 36}, 32'h1);
    hold <= 1'b1;
    repeat (170) @(posedge mclk);
    hold <= 1'b0;
    fin();
    rc(berc_pkg::OFF_RES_TOT, 32'd320);
    rc(berc_pkg::OFF_RES_ERR, 32'h0);
    wr32(berc_pkg::OFF_TOTAL, 32'd128);
    wr32(berc_pkg::OFF_RESYNC, 32'h1);
    wr32(berc_pkg::OFF_FAIL_LIM, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr32(berc_pkg::OFF_CYCLES, ecy[i]);
      go(ectl[i]);
      wait_lock();
      repeat (3) begin
        @(posedge mclk);
        err <= 1'b1;
        @(posedge mclk);
        err <= 1'b0;
      end
      fin();
      rc(berc_pkg::OFF_RES_ERR, eer[i]);
      rc(berc_pkg::OFF_CYC_DONE, ecy[i]);
      rd32(berc_pkg::OFF_STATUS, v);
      chk(v & 32'h8, efl[i]);
      chk(v & 32'h4, elo[i]);
    end
    wrap_up();
  end
endmodule // testbench
bind berc_top berc_assertions u_chk (.clk_i, .reset_n_i, .trigger_i, .addr_i,
  .rd_i, .rdata_o, .measurement_active_output_o, .result_pulse_output_o);
`default_nettype wire
